// File: pkg/strap_pkg.sv
// Constants shared by the board reset combiner and mode strap driver
// Operation
// [R1] Any of three reset requests pulls pin low
// [R2] Buffer reset pin into board reset output
// [R3] Debug test-logic reset never reaches reset combiner
// [R4] Drive seven straps only while reset low
// [R5] Switch ON gives 0, OFF gives 1
// [R6] Boot vector strap defaults to 0
// [R7] Chip mode strap defaults to 1 (expanded)
// [R8] Oscillator type strap defaults to 1
// [R9] Port width strap defaults to 1 (16-bit)
// [R10] Auto acknowledge strap defaults to 1
// [R11] Trace location strap defaults to 1 (secondary)
// [R12] Trace enable strap defaults to 1 (present)
// [R13] Probe reset buffered by default, optionally direct
// [R14] Hold active trace event line high when enabled
// [R15] Primary trace location needs 16-bit memories disabled
// [R16] Release straps once reset seen deasserted
package strap_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STRAP_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_REG_BIT = 0;
  localparam int CTRL_DIRECT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Strap field positions and defaults
  // ----------------------------------------------------------------
  localparam int NUM_STRAPS = 7;
  localparam int BOOT_VECTOR_BIT = 0;
  localparam int CHIP_MODE_BIT = 1;
  localparam int OSC_TYPE_BIT = 2;
  localparam int PORT_WIDTH_BIT = 3;
  localparam int AUTO_ACK_BIT = 4;
  localparam int TRACE_LOC_BIT = 5;
  localparam int TRACE_EN_BIT = 6;
  localparam logic [6:0] STRAP_DEFAULT = 7'h7E;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_REQ_LSB = 1;
  localparam int STAT_DRIVING_BIT = 4;
  localparam int STAT_CONFLICT_BIT = 5;
  localparam int STAT_DIRECT_BIT = 6;
  localparam int STAT_EFF_LSB = 8;
  localparam int STAT_PIN_LSB = 16;

endpackage : strap_pkg

// File: design/sync2.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sync2
`default_nettype wire

// File: design/reset_strap.sv
// Board reset combiner, reset buffer and reset-time mode strap driver
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module reset_strap
  import strap_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External reset requests, active low
  input wire logic probe_reset_n,
  input wire logic connector_reset_n,
  input wire logic undervoltage_reset_n,
  // Debug test-logic reset, passed to the processor only
  input wire logic probe_trst_n,
  output logic mcu_trst_n,
  // Processor bidirectional reset pin, open drain
  input wire logic mcu_reset_i,
  output logic mcu_reset_o,
  output logic mcu_reset_oe,
  // Buffered board reset and probe view of reset
  output logic board_reset_n,
  output logic probe_reset_sense_n,
  // Strap switch bank, high while a switch is ON
  input wire logic [NUM_STRAPS-1:0] strap_switch_bank,
  // Processor strap pins
  input wire logic [NUM_STRAPS-1:0] strap_i,
  output logic [NUM_STRAPS-1:0] strap_o,
  output logic [NUM_STRAPS-1:0] strap_oe,
  // Trace event-in hold, primary and secondary location
  output logic trace_event_in_n_pri_hold,
  output logic trace_event_in_n_sec_hold
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 4 + 1 + 2 * NUM_STRAPS;
  localparam logic [SW-1:0] SYNC_INIT = {{(2 * NUM_STRAPS){1'b0}}, 5'h1F};

  logic [SW-1:0] sync_d;
  logic [SW-1:0] sync_q;
  logic probe_s;
  logic connector_s;
  logic uv_s;
  logic pin_s;
  logic trst_s;
  logic [NUM_STRAPS-1:0] switch_s;
  logic [NUM_STRAPS-1:0] strap_pin_s;

  assign sync_d = {strap_i, strap_switch_bank, probe_trst_n, mcu_reset_i,
                   undervoltage_reset_n, connector_reset_n, probe_reset_n};

  sync2 #(
    .W(SW),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(sync_d),
    .q(sync_q)
  );

  assign probe_s = sync_q[0];
  assign connector_s = sync_q[1];
  assign uv_s = sync_q[2];
  assign pin_s = sync_q[3];
  assign trst_s = sync_q[4];
  assign switch_s = sync_q[5 +: NUM_STRAPS];
  assign strap_pin_s = sync_q[5 + NUM_STRAPS +: NUM_STRAPS];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [NUM_STRAPS-1:0] strap_reg_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // Reset combining
  // ----------------------------------------------------------------
  logic [2:0] req;
  logic any_req;
  logic direct;
  logic drive_q;
  logic zero_q;
  logic board_q;
  logic sense_q;
  logic trst_q;

  // Each request alone is enough; none masks another
  assign req = {~uv_s, ~connector_s, ~probe_s}; // R1
  assign any_req = |req; // R1
  assign direct = ctrl_q[CTRL_DIRECT_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
      zero_q <= 1'b0;
      board_q <= 1'b0;
      sense_q <= 1'b0;
      trst_q <= 1'b0;
    end else begin
      drive_q <= any_req; // R1
      zero_q <= 1'b0;
      board_q <= pin_s; // R2
      // Buffering hides the pin from the probe; direct wiring shows it
      sense_q <= direct ? pin_s : probe_s; // R13
      // Test-logic reset goes to the processor alone, not the combiner
      trst_q <= trst_s; // R3
    end
  end

  assign mcu_reset_o = zero_q;
  assign mcu_reset_oe = drive_q;
  assign board_reset_n = board_q;
  assign probe_reset_sense_n = sense_q;
  assign mcu_trst_n = trst_q;

  // ----------------------------------------------------------------
  // Strap drivers
  // ----------------------------------------------------------------
  logic [NUM_STRAPS-1:0] switch_val;
  logic [NUM_STRAPS-1:0] eff_val;
  logic [NUM_STRAPS-1:0] strap_o_q;
  logic [NUM_STRAPS-1:0] strap_oe_q;
  logic [NUM_STRAPS-1:0] latched_q;
  logic pri_hold_q;
  logic sec_hold_q;
  logic conflict;

  // A switch that is ON reads as logic 0
  assign switch_val = ~switch_s; // R5
  // Register source starts from the documented defaults
  assign eff_val = ctrl_q[CTRL_SRC_REG_BIT] ? strap_reg_q : switch_val; // R6 R7 R8 R9 R10 R11 R12

  // Primary location narrows the bus to 8 bits, so 16-bit memories misbehave
  assign conflict = latched_q[TRACE_EN_BIT] & ~latched_q[TRACE_LOC_BIT]
                  & latched_q[PORT_WIDTH_BIT]; // R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_o_q <= STRAP_DEFAULT;
      strap_oe_q <= '0;
      latched_q <= STRAP_DEFAULT;
    end else begin
      strap_o_q <= eff_val;
      strap_oe_q <= {NUM_STRAPS{~pin_s}}; // R4 R16
      if (!pin_s) begin
        latched_q <= eff_val; // R4
      end
    end
  end

  // Hold event-in high on the active location only, avoiding contention elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_hold_q <= 1'b0;
      sec_hold_q <= 1'b0;
    end else begin
      pri_hold_q <= latched_q[TRACE_EN_BIT] & ~latched_q[TRACE_LOC_BIT]; // R14
      sec_hold_q <= latched_q[TRACE_EN_BIT] & latched_q[TRACE_LOC_BIT]; // R14
    end
  end

  assign strap_o = strap_o_q;
  assign strap_oe = strap_oe_q;
  assign trace_event_in_n_pri_hold = pri_hold_q;
  assign trace_event_in_n_sec_hold = sec_hold_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access;
  logic sel_ctrl;
  logic sel_strap;
  logic sel_status;
  logic mapped;
  logic wr_ctrl;
  logic wr_strap;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // One wait state: pready rises on the second access cycle
  assign access = psel & penable & ~pready_q;
  assign sel_ctrl = paddr == CTRL_OFFS;
  assign sel_strap = paddr == STRAP_OFFS;
  assign sel_status = paddr == STATUS_OFFS;
  assign mapped = sel_ctrl | sel_strap | sel_status;
  assign wr_ctrl = access & pwrite & sel_ctrl;
  assign wr_strap = access & pwrite & sel_strap;

  assign status_word = {9'h000, strap_pin_s, 1'b0, latched_q, 1'b0, direct, conflict,
                        strap_oe_q[0], req, pin_s};
  assign rd_mux = sel_ctrl ? {30'h00000000, ctrl_q} :
                  sel_strap ? {25'h0000000, strap_reg_q} :
                  sel_status ? status_word : 32'h00000000;

  // Bits above each field are dropped on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      strap_reg_q <= STRAP_DEFAULT; // R6 R7 R8 R9 R10 R11 R12
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (wr_strap) begin
        strap_reg_q <= pwdata[NUM_STRAPS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~mapped;
      prdata_q <= (access & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  combine_drive_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    any_req |=> mcu_reset_oe && !mcu_reset_o)
    else $error("reset request did not pull the pin low");

  combine_release_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    !any_req |=> !mcu_reset_oe)
    else $error("pin driven with no reset request");

  board_buffer_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    $fell(pin_s) |=> !board_reset_n)
    else $error("board reset does not follow the reset pin");

  board_release_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    $rose(pin_s) |=> board_reset_n)
    else $error("board reset not released with the reset pin");

  trst_isolated_a: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    (!trst_s && !any_req) |=> !mcu_reset_oe && !mcu_trst_n)
    else $error("test-logic reset leaked into the reset combiner");

  strap_drive_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    !pin_s |=> (strap_oe == {NUM_STRAPS{1'b1}}) && (strap_o == $past(eff_val)))
    else $error("straps not driven while reset is low");

  strap_release_a: assert property ( // R16
    @(posedge pclk) disable iff (!presetn)
    pin_s[*2] |=> strap_oe == '0)
    else $error("straps still driven after reset release");

  switch_polarity_a: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q[CTRL_SRC_REG_BIT] && $stable(switch_s)) |=> strap_o_q == ~$past(switch_s))
    else $error("switch ON did not give logic 0");

  event_hold_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    latched_q[TRACE_EN_BIT] |=>
      (trace_event_in_n_sec_hold == $past(latched_q[TRACE_LOC_BIT])) &&
      (trace_event_in_n_pri_hold != trace_event_in_n_sec_hold))
    else $error("trace event-in not held on the active location");

  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access start");

  strap_latch_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    !pin_s |=> latched_q == $past(eff_val))
    else $error("strap values not captured while reset is low");

  latch_hold_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    pin_s |=> $stable(latched_q))
    else $error("captured straps changed outside reset");

  trst_follow_a: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    trst_s |=> mcu_trst_n)
    else $error("test-logic reset held without a request");

  probe_sense_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    !direct |=> probe_reset_sense_n == $past(probe_s))
    else $error("buffered probe view does not show its own request");

  direct_sense_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    direct |=> probe_reset_sense_n == $past(pin_s))
    else $error("direct probe view does not show the reset pin");

  event_idle_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    !latched_q[TRACE_EN_BIT] |=> !trace_event_in_n_pri_hold && !trace_event_in_n_sec_hold)
    else $error("trace event-in held while trace is absent");

  apb_error_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !mapped) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  ctrl_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ctrl_q == $past(pwdata[1:0]))
    else $error("control write did not land");

  strap_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_strap |=> strap_reg_q == $past(pwdata[NUM_STRAPS-1:0]))
    else $error("strap write did not land");

  read_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data shown outside the answer cycle");

endmodule : reset_strap
`default_nettype wire

// File: test/mcu_pins.sv
// Behavioural model of the processor reset pin and its mode pins
`timescale 1ns/1ns
`default_nettype none
module mcu_pins (
  // Clock and board side drive
  input wire logic clk,
  input wire logic reset_o,
  input wire logic reset_oe,
  input wire logic self_reset,
  input wire logic [6:0] strap_o,
  input wire logic [6:0] strap_oe,
  // Pin levels
  output logic pin,
  output logic [6:0] strap_pin,
  output logic [6:0] latched
);
  logic [6:0] last_q = 7'h00;
  // Open drain with pull-up; the processor may also pull it low itself
  assign pin = ~((reset_oe & ~reset_o) | self_reset);
  // A released strap pin floats, so show the inverse of its last driven level
  assign strap_pin = (strap_oe & strap_o) | (~strap_oe & ~last_q);
  always_ff @(posedge clk) begin
    last_q <= (strap_oe & strap_o) | (~strap_oe & last_q);
  end
  // Mode is taken as reset rises
  always_ff @(posedge pin) begin
    latched <= strap_pin;
  end
endmodule : mcu_pins
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the reset combiner and strap driver
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import strap_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, pwd;
  logic pready, pslverr, er, pin, self_reset = 0, probe_trst_n = 1;
  logic [2:0] req_n = 3'h7;
  logic [6:0] sw = 7'h00, strap_o, strap_oe, strap_pin, latched;
  logic mcu_trst_n, rst_o, rst_oe, board_reset_n, sense_n, pri_hold, sec_hold;
  int errors = 0, checks = 0, seed = 32'h5600;

  always #5 pclk = ~pclk;

  reset_strap uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .probe_reset_n(req_n[0]), .connector_reset_n(req_n[1]),
    .undervoltage_reset_n(req_n[2]), .probe_trst_n(probe_trst_n), .mcu_trst_n(mcu_trst_n),
    .mcu_reset_i(pin), .mcu_reset_o(rst_o), .mcu_reset_oe(rst_oe),
    .board_reset_n(board_reset_n), .probe_reset_sense_n(sense_n),
    .strap_switch_bank(sw), .strap_i(strap_pin), .strap_o(strap_o), .strap_oe(strap_oe),
    .trace_event_in_n_pri_hold(pri_hold), .trace_event_in_n_sec_hold(sec_hold));

  mcu_pins far_end (.clk(pclk), .reset_o(rst_o), .reset_oe(rst_oe), .self_reset(self_reset),
    .strap_o(strap_o), .strap_oe(strap_oe), .pin(pin), .strap_pin(strap_pin),
    .latched(latched));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] eff(input logic src, input logic [6:0] s, input logic [6:0] r);
    return src ? r : ~s;
  endfunction : eff

  function automatic logic [31:0] stat(input logic [6:0] e, input logic d);
    return {9'h000, ~e, 1'b0, e, 1'b0, d, e[TRACE_EN_BIT] & ~e[TRACE_LOC_BIT] & e[PORT_WIDTH_BIT],
            5'h01};
  endfunction : stat

  task automatic print_verdict;
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Request k below 3 is an external source, 3 is the processor itself
  task automatic pulse(input int k, input logic [6:0] e);
    @(posedge pclk);
    if (k < 3) req_n[k] <= 1'b0;
    else self_reset <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({rst_oe, rst_o}, {k < 3, 1'b0});
    chk(board_reset_n, 0);
    chk(strap_oe, 7'h7F);
    chk(strap_o, e);
    chk({pri_hold, sec_hold}, {e[6] & ~e[5], e[6] & e[5]});
    req_n <= 3'h7;
    self_reset <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(rst_oe, 0);
    chk(strap_oe, 0);
    chk(latched, e);
  endtask : pulse

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(board_reset_n, 1);
    chk(strap_oe, 0);
    apb(0, CTRL_OFFS, 0);
    chk(rd, 0);
    apb(0, STRAP_OFFS, 0);
    chk(rd, 32'h0000_007E);
    apb(0, 8'h0C, 0);
    chk(er, 1);
    chk(rd, 0);
    for (int i = 0; i < 8; i++) begin
      sw <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($random(seed));
      repeat (4) @(posedge pclk);
      pulse(i % 4, eff(0, sw, 0));
    end
    probe_trst_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({mcu_trst_n, rst_oe, pin}, 3'b001);
    probe_trst_n <= 1'b1;
    // Trace on primary pins with a 16-bit port forces the conflict flag
    pwd = ($random(seed) & 32'hFFFF_FFDF) | 32'h0000_0048;
    apb(1, STRAP_OFFS, pwd);
    apb(0, STRAP_OFFS, 0);
    chk(rd, pwd & 32'h7F);
    apb(1, CTRL_OFFS, 32'hFFFF_FFFD);
    apb(0, CTRL_OFFS, 0);
    chk(rd, 1);
    pulse(1, eff(1, sw, pwd[6:0]));
    apb(0, STATUS_OFFS, 0);
    chk(rd, stat(pwd[6:0], 0));
    for (int m = 0; m < 2; m++) begin
      apb(1, CTRL_OFFS, 32'(2 * m));
      self_reset <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(sense_n, m == 0);
      self_reset <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
